// ### rtl/deser_pkg.sv
// Shared constants of the 21-bit forwarded-clock deserializer.
// Assumes a 200 MHz system clock that oversamples the link clock and the serial lanes.
package deser_pkg;

  // ************************************************************
  // Link shape
  // ************************************************************
  localparam int LANES = 3; // Serial data lanes
  localparam int SLOTS = 7; // Bits per lane per link clock period
  localparam int WORD_W = LANES * SLOTS; // Parallel word width (21)

  // ************************************************************
  // Timing figures and derived cycle counts
  // ************************************************************
  localparam int SYS_PERIOD_PS = 5000; // System clock period
  localparam longint LOCK_TIME_MS = 10; // Longest lock time after wake-up
  localparam longint LOCK_CYCLES = (LOCK_TIME_MS * 64'd1000000000) / SYS_PERIOD_PS; // Round down
  localparam int SLEEP_DELAY_US = 1; // Longest delay into the sleep output state
  localparam int SLEEP_DELAY_CYCLES = (SLEEP_DELAY_US * 1000000) / SYS_PERIOD_PS; // Round down
  localparam int LOSS_TIME_NS = 100; // Link clock silence that counts as lost
  localparam int LOSS_CYCLES = (LOSS_TIME_NS * 1000 + SYS_PERIOD_PS - 1) / SYS_PERIOD_PS; // Round up

  // ************************************************************
  // Widths and reset values
  // ************************************************************
  localparam int PHASE_W = 8; // Phase counter width, holds LOSS_CYCLES
  localparam logic [WORD_W-1:0] WORD_RESET = '0; // Parallel word after reset
  localparam logic [LANES+1:0] SYNC_RESET = {1'b0, 1'b1, {LANES{1'b1}}}; // Sleep asserted, clock and lanes idle high

endpackage

// ### rtl/link_sync3.sv
// Three-stage input synchroniser with agreement filter.
// Assumes asynchronous inputs; output moves once stages two and three agree.
`timescale 1ns/1ps

module link_sync3 #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic i_ce,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_stable
);

  // ************************************************************
  // Per-bit synchroniser chain
  // ************************************************************
  genvar b;
  generate
    for (b = 0; b < W; b++) begin : g_bit
      logic q1_r; // First stage, read only by the second
      logic q2_r; // Second stage
      logic q3_r; // Third stage
      logic st_r; // Filtered value
      logic st_nxt; // Next filtered value

      // Accept a change only when stages two and three agree
      always_comb begin
        st_nxt = (q2_r == q3_r) ? q3_r : st_r;
      end

      // Register the chain
      always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
          q1_r <= INIT[b];
          q2_r <= INIT[b];
          q3_r <= INIT[b];
          st_r <= INIT[b];
        end else if (i_ce) begin
          q1_r <= i_async[b];
          q2_r <= q1_r;
          q3_r <= q2_r;
          st_r <= st_nxt;
        end
      end

      assign o_stable[b] = st_r;
    end
  endgenerate

endmodule // link_sync3

// ### rtl/lvds_21bit_deserializer.sv
// Receive end of a forwarded-clock serial link: three lanes to one 21-bit word.
// Assumes the system clock oversamples the link clock well; all link pins are asynchronous.
`timescale 1ns/1ps

module lvds_21bit_deserializer #(
  parameter longint LOCK_CYCLES_P = deser_pkg::LOCK_CYCLES // Shorten for simulation
) (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic i_ce,
  input wire logic [deser_pkg::LANES-1:0] i_serial_lane_in,
  input wire logic i_forwarded_clock_in,
  input wire logic i_sleep_request_n,
  output logic [deser_pkg::WORD_W-1:0] o_parallel_word_out,
  output logic o_recovered_clock_out
);
  import deser_pkg::*;

  // ************************************************************
  // Input synchronisers
  // ************************************************************
  logic [LANES-1:0] lane_s; // Filtered lane levels
  logic clk_s; // Filtered forwarded clock
  logic sleep_n_s; // Filtered sleep request, low means sleep

  // All link pins cross into the system domain here
  link_sync3 #(
    .W(LANES + 2),
    .INIT(SYNC_RESET)
  ) u_sync (
    .i_clk_sys(i_clk_sys),
    .i_reset(i_reset),
    .i_ce(i_ce),
    .i_async({i_sleep_request_n, i_forwarded_clock_in, i_serial_lane_in}),
    .o_stable({sleep_n_s, clk_s, lane_s})
  );

  // ************************************************************
  // Clock tracking and lock state
  // ************************************************************
  logic clk_prev_r, clk_prev_nxt; // Last filtered clock level
  logic [PHASE_W-1:0] phase_r, phase_nxt; // Cycles since last rising edge
  logic [PHASE_W-1:0] period_r, period_nxt; // Measured link period in cycles
  logic clock_ok_r, clock_ok_nxt; // Forwarded clock present
  logic [31:0] lock_cnt_r, lock_cnt_nxt; // Lock timer
  logic rise; // Rising edge of forwarded clock
  logic locked; // Lock reached

  // Find edges, measure period, flag loss, run lock timer
  always_comb begin
    clk_prev_nxt = clk_s;
    rise = clk_s & ~clk_prev_r;
    phase_nxt = phase_r;
    period_nxt = period_r;
    clock_ok_nxt = clock_ok_r;
    lock_cnt_nxt = lock_cnt_r;
    locked = (lock_cnt_r == 32'(LOCK_CYCLES_P));
    if (rise) begin
      // New frame starts
      period_nxt = phase_r + 8'h01;
      phase_nxt = '0;
      clock_ok_nxt = 1'b1;
    end else if (phase_r != PHASE_W'(LOSS_CYCLES)) begin
      phase_nxt = phase_r + 8'h01;
    end else begin
      // Silence too long: clock counts as lost
      clock_ok_nxt = 1'b0;
    end
    if (!sleep_n_s || !clock_ok_r) begin
      // Lock restarts on wake-up or clock return
      lock_cnt_nxt = '0;
    end else if (!locked) begin
      lock_cnt_nxt = lock_cnt_r + 32'h1;
    end
  end

  // Register clock tracking
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      // Idle-high clock level, so leaving reset shows no false rise
      clk_prev_r <= 1'b1;
      phase_r <= '0;
      period_r <= '0;
      clock_ok_r <= 1'b0;
      lock_cnt_r <= '0;
    end else if (i_ce) begin
      clk_prev_r <= clk_prev_nxt;
      phase_r <= phase_nxt;
      period_r <= period_nxt;
      clock_ok_r <= clock_ok_nxt;
      lock_cnt_r <= lock_cnt_nxt;
    end
  end

  // ************************************************************
  // Bit slot sampling and word output
  // ************************************************************
  logic [2:0] slot_r, slot_nxt; // Next bit slot to sample
  logic [WORD_W-1:0] assemble_r, assemble_nxt; // Frame under assembly
  logic [WORD_W-1:0] word_r, word_nxt; // Delivered word
  logic valid_r, valid_nxt; // Word is a valid delivered frame
  logic clk_out_r, clk_out_nxt; // Recovered clock
  logic [11:0] mul; // Slot centre times period
  logic [11:0] thresh; // Cycles after the rise cycle at which current slot is sampled
  logic sample_en; // Sample the lanes this cycle
  logic load; // Deliver the assembled frame

  // Sample slot centres, assemble, deliver on the next edge
  always_comb begin
    mul = 12'({slot_r, 1'b1}) * 12'(period_r);
    thresh = mul / 12'(2 * SLOTS);
    slot_nxt = slot_r;
    assemble_nxt = assemble_r;
    word_nxt = word_r;
    valid_nxt = valid_r;
    sample_en = 1'b0;
    load = rise && locked && clock_ok_r && sleep_n_s && (slot_r == 3'(SLOTS));
    // Slot k is taken (2k+1)*P/14 cycles after the rise cycle, which counts as phase -1.
    // A period under 14 cycles is refused: each bit needs two samples to pass the pin filter.
    if (rise) begin
      slot_nxt = '0;
    end else if ((slot_r < 3'(SLOTS)) && (({4'h0, phase_r} + 12'h001) == thresh)) begin
      // Seven slots share one period
      sample_en = 1'b1;
      slot_nxt = slot_r + 3'h1;
      for (int l = 0; l < LANES; l++) begin
        // Idle-high lanes fill the frame with ones
        assemble_nxt[l * SLOTS + int'(slot_r)] = lane_s[l];
      end
    end
    if (!sleep_n_s) begin
      // Sleep drives the word low
      word_nxt = WORD_RESET;
      valid_nxt = 1'b0;
    end else if (load) begin
      // All bits leave together
      word_nxt = assemble_r;
      valid_nxt = 1'b1;
    end else if (!clock_ok_r || !locked) begin
      // Word holds its value, only the strobe stops
      valid_nxt = 1'b0;
    end
    // Strobe rises one cycle after the word changes
    clk_out_nxt = valid_r && clock_ok_r && sleep_n_s && locked && (phase_nxt != '0) &&
                  (phase_nxt <= (period_r >> 1));
  end

  // Register the data path
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      slot_r <= '0;
      assemble_r <= WORD_RESET;
      word_r <= WORD_RESET;
      valid_r <= 1'b0;
      clk_out_r <= 1'b0;
    end else if (i_ce) begin
      slot_r <= slot_nxt;
      assemble_r <= assemble_nxt;
      word_r <= word_nxt;
      valid_r <= valid_nxt;
      clk_out_r <= clk_out_nxt;
    end
  end

  assign o_parallel_word_out = word_r;
  assign o_recovered_clock_out = clk_out_r;

  // ************************************************************
  // Assertions
  // ************************************************************
  localparam int SLEEP_LIMIT = SLEEP_DELAY_CYCLES; // Bound for sleep entry

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_reset || !i_ce);

  sequence seq_load;
    load ##1 (word_r == $past(assemble_r));
  endsequence

  sequence seq_strobe;
    !o_recovered_clock_out ##1 o_recovered_clock_out;
  endsequence

  a_word_whole_frame: assert property (rise && (slot_r == 3'(SLOTS)) && locked && clock_ok_r && sleep_n_s
    |-> seq_load)
    else $error("frame not delivered as one word");

  a_strobe_after_word: assert property (load ##1 (i_ce && sleep_n_s) |-> seq_strobe)
    else $error("strobe did not rise one cycle after word");

  a_sleep_word_low: assert property (!sleep_n_s |=> (o_parallel_word_out == '0) && !o_recovered_clock_out)
    else $error("outputs not low in sleep");

  a_sleep_entry_time: assert property ($fell(i_sleep_request_n) ##1 !i_sleep_request_n [*4]
    |-> ##[0:SLEEP_LIMIT] (o_parallel_word_out == '0))
    else $error("sleep state not reached in time");

  a_ones_frame: assert property (load && (&assemble_r) |=> (&o_parallel_word_out))
    else $error("idle-high frame not delivered as ones");

  a_lost_hold: assert property (!clock_ok_r && sleep_n_s && $past(sleep_n_s) |=> $stable(o_parallel_word_out))
    else $error("word changed without forwarded clock");

  a_lost_clock_low: assert property ($fell(clock_ok_r) |-> !o_recovered_clock_out [*4])
    else $error("recovered clock active without forwarded clock");

  a_lock_gate: assert property ($rose(valid_r) |-> $past(lock_cnt_r) == 32'(LOCK_CYCLES_P))
    else $error("word delivered before lock");

  a_slot_map: assert property (sample_en |=> assemble_r[SLOTS + int'($past(slot_r))] == $past(lane_s[1]))
    else $error("lane bit stored at wrong position");

endmodule // lvds_21bit_deserializer

// ### bench/ser_model.sv
// Behavioural far-end serializer: three lanes plus forwarded clock.
// Assumes idle or floating pins read high, as the input bias makes them.
`timescale 1ns/1ps

module ser_model #(
  parameter real PERIOD_NS = 70.0 // Link clock period; every bit must span two system clock samples
) (
  input wire logic i_run,
  input wire logic i_float,
  input wire logic [20:0] i_word,
  output logic o_clk,
  output logic [2:0] o_lanes
);
  logic [20:0] frame_r; // Word being shifted out
  logic float_r; // Lane float state for this frame

  // ************************************************************
  // Frame generator
  // ************************************************************
  // Controls are taken only at frame starts, so no frame is cut short
  initial begin
    o_clk = 1'b1;
    o_lanes = 3'b111;
    forever begin
      if (i_run) begin
        frame_r = i_word;
        float_r = i_float;
        for (int k = 0; k < 7; k++) begin
          o_clk = (k < 4); // Clock driven; lanes driven unless floating, then read high
          for (int l = 0; l < 3; l++) begin
            o_lanes[l] = float_r ? 1'b1 : frame_r[l*7+k]; // Seven slots, bit lane*7+slot
          end
          #(PERIOD_NS / 7.0);
        end
      end else begin
        o_clk = 1'b1; // Floating clock pin reads high and stands still
        o_lanes = 3'b111;
        #(PERIOD_NS / 7.0);
      end
    end
  end
endmodule // ser_model

// ### bench/lvds_21bit_deserializer_tb.sv
// Bench of the deserializer: patterns, failsafe, freeze, link loss, sleep and wake.
// Assumes ser_model as far end and a lock count shortened to 50.
`timescale 1ns/1ps

module lvds_21bit_deserializer_tb;
  import deser_pkg::*;
  logic i_clk_sys = 1'b0; // System clock
  logic i_reset = 1'b1; // Reset, held two cycles
  logic i_sleep_request_n = 1'b1; // Awake
  logic run = 1'b0; // Far-end clock running
  logic flt = 1'b0; // Far-end lanes floating
  logic ce = 1'b1; // Clock enable of the device
  logic [WORD_W-1:0] tx_word = '0; // Word sent
  logic [WORD_W-1:0] word; // Word received
  logic strobe; // Recovered clock
  logic fclk; // Forwarded clock pin
  logic [LANES-1:0] lanes; // Lane pins
  int n_fail = 0;
  int cmp_count = 0;
  logic [WORD_W-1:0] pats [5] = '{21'h155555, 21'h0aaaaa, 21'h000001, 21'h100000, 21'h1c0e07};

  // ************************************************************
  // Clock, far end and device
  // ************************************************************
  always #2.5 i_clk_sys = ~i_clk_sys;
  ser_model ser_model_inst (.i_run(run), .i_float(flt), .i_word(tx_word), .o_clk(fclk), .o_lanes(lanes));
  lvds_21bit_deserializer #(.LOCK_CYCLES_P(50)) lvds_21bit_deserializer_inst (
    .i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_ce(ce), .i_serial_lane_in(lanes),
    .i_forwarded_clock_in(fclk), .i_sleep_request_n(i_sleep_request_n),
    .o_parallel_word_out(word), .o_recovered_clock_out(strobe));

  // ************************************************************
  // Shared tasks
  // ************************************************************
  // Compare and count
  task automatic check(input string name, input logic [WORD_W-1:0] seen, input logic [WORD_W-1:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Counts, verdict, end of run
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Far-end controls change just after a rising edge
  task automatic drive(input logic r, input logic f, input logic [WORD_W-1:0] w);
    @(posedge i_clk_sys);
    run <= r;
    flt <= f;
    tx_word <= w;
  endtask

  // Wait for n strobe rises, bounded; a hang ends the run
  task automatic wait_strobe(input int n);
    logic prev;
    int t;
    prev = strobe;
    t = 0;
    while (n > 0) begin
      @(negedge i_clk_sys);
      t++;
      if (strobe === 1'b1 && prev !== 1'b1) n--;
      prev = strobe;
      if (t > 400) begin
        n_fail++;
        $display("Error strobe expected rise seen none");
        print_verdict();
      end
    end
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  // Each pattern arrives whole at the strobe rise
  task automatic t_patterns();
    foreach (pats[i]) begin
      drive(1'b1, 1'b0, pats[i]);
      wait_strobe(3);
      check("word", word, pats[i]);
    end
  endtask

  // Floating lanes with clock running give all ones
  task automatic t_failsafe();
    drive(1'b1, 1'b1, '0);
    wait_strobe(3);
    check("failsafe word", word, '1);
  endtask

  // Clock and lanes lost: word holds, strobe low
  task automatic t_loss();
    drive(1'b1, 1'b0, pats[4]);
    wait_strobe(3);
    drive(1'b0, 1'b1, '0);
    repeat (40) @(negedge i_clk_sys);
    repeat (60) begin
      @(negedge i_clk_sys);
      check("held word", word, pats[4]);
      check("strobe", WORD_W'(strobe), '0);
    end
  endtask

  // Clock enable low freezes word and strobe; delivery resumes afterwards
  task automatic t_freeze();
    drive(1'b1, 1'b0, pats[2]);
    wait_strobe(3);
    @(posedge i_clk_sys);
    ce <= 1'b0;
    repeat (30) begin
      @(negedge i_clk_sys);
      check("frozen word", word, pats[2]);
      check("frozen strobe", WORD_W'(strobe), WORD_W'(1));
    end
    @(posedge i_clk_sys);
    ce <= 1'b1;
    wait_strobe(3);
    check("resumed word", word, pats[2]);
  endtask

  // Sleep forces zeros within the delay; wake relocks and delivers
  task automatic t_sleep();
    int t;
    drive(1'b1, 1'b0, pats[1]);
    wait_strobe(3);
    @(posedge i_clk_sys);
    i_sleep_request_n <= 1'b0;
    for (t = 0; t < SLEEP_DELAY_CYCLES; t++) begin
      @(negedge i_clk_sys);
      if (word === '0 && strobe === 1'b0) break;
    end
    check("sleep delay", WORD_W'(t < SLEEP_DELAY_CYCLES), WORD_W'(1));
    repeat (40) begin
      @(negedge i_clk_sys);
      check("sleep word", word | WORD_W'(strobe), '0);
    end
    @(posedge i_clk_sys);
    i_sleep_request_n <= 1'b1;
    // Lock timer of 50 cycles restarts on wake: nothing is delivered before it runs out
    repeat (50) begin
      @(negedge i_clk_sys);
      check("word before lock", word | WORD_W'(strobe), '0);
    end
    wait_strobe(3);
    check("wake word", word, pats[1]);
  endtask

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    repeat (2) @(posedge i_clk_sys);
    i_reset <= 1'b0;
    t_patterns();
    t_failsafe();
    t_freeze();
    t_loss();
    t_sleep();
    print_verdict();
  end
endmodule // lvds_21bit_deserializer_tb
